/* File: rtl/fcp_pkg.sv */
package fcp_pkg;
    localparam logic [10:0] ADR_555 = 11'h555;
    localparam logic [10:0] ADR_2AA = 11'h2aa;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_CFG_ENTER = 8'hd0;
    localparam logic [7:0] CMD_OTP_ENTER = 8'h88;
    localparam logic [7:0] CMD_LOAD = 8'h25;
    localparam logic [7:0] CMD_COMMIT = 8'h29;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_ERASE_GO = 8'h30;
    localparam logic [7:0] CMD_PROT = 8'h60;
    localparam logic [7:0] CMD_RANGE = 8'h61;
    localparam logic [7:0] CMD_STAT = 8'h70;
    localparam logic [7:0] CMD_CLR = 8'h71;
    localparam logic [7:0] WC_ONE = 8'h00;
    localparam logic [15:0] CR_RST = 16'hdfc8;
    localparam int CR_SYNC_B = 15;
    localparam int CR_LAT_HI = 14;
    localparam int CR_LAT_LO = 11;
    localparam int CR_POL_B = 10;
    localparam int CR_DRV_B = 7;
    localparam logic [3:0] LAT_BAD = 4'hb;
    localparam logic [3:0] LAT_MIN = 4'h1;
    localparam logic [3:0] LAT_MAX = 4'h8;
    localparam logic [4:0] LAT_OFS = 5'h02;
    localparam logic [2:0] BL_CONT = 3'h0;
    localparam logic [2:0] BL_W8 = 3'h2;
    localparam logic [2:0] BL_W16 = 3'h3;
    localparam int ST_RDY = 7;
    localparam int ST_PFAIL = 4;
    localparam int ST_PROT = 1;
    localparam int LOCK_CUST = 0;
    localparam int LOCK_FACT = 1;
    localparam int PROT_SEL_BIT = 6;
    localparam int OTP_WORDS = 256;
    localparam logic [15:0] OTP_BLANK = 16'hffff;
    typedef struct packed {
        logic [7:0] sect;
        logic [15:0] low;
    } fcp_cycle_t;
    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic avd_n;
        logic bclk;
        logic wp_n;
    } fcp_pins_t;
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00, SQ_C1 = 2'b01, SQ_C2 = 2'b10, SQ_C3 = 2'b11
    } fcp_seq_t;
    typedef enum logic [1:0] {
        MD_ARRAY = 2'b00, MD_CFG = 2'b01, MD_OTP = 2'b10, MD_STAT = 2'b11
    } fcp_mode_t;
    typedef enum logic [1:0] {
        BU_IDLE = 2'b00, BU_LAT = 2'b01, BU_DATA = 2'b10
    } fcp_burst_t;
endpackage

/* File: rtl/fcp_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser; idles high like the bus pins
module fcp_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '1;
            q_o <= '1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: rtl/fcp_flash_cmd.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module fcp_flash_cmd import fcp_pkg::*; #(
    parameter logic [15:0] LOCK_INIT = 16'hffff
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic chip_sel_n_i,
    input wire logic out_en_n_i,
    input wire logic write_en_n_i,
    input wire logic address_valid_n_i,
    input wire logic burst_clk_i,
    input wire logic write_protect_n_i,
    input wire logic [15:0] muxed_addr_data_lines_i,
    input wire logic [7:0] sector_base_addr_i,
    output logic [15:0] muxed_addr_data_lines_o,
    output logic muxed_oe_n_o,
    output logic ready_o,
    output logic ready_oe_n_o,
    output logic drive_half_o,
    input wire logic pe_busy_i,
    input wire logic [15:0] array_rdata_i,
    output logic [23:0] array_addr_o,
    output logic pe_start_o,
    output logic pe_erase_o,
    output logic [23:0] pe_addr_o,
    output logic [15:0] pe_data_o
);
    logic [29:0] sync_q;
    fcp_pins_t pin_s;
    logic [15:0] mad_s;
    logic [7:0] sect_s;
    logic we_n_q, avd_n_q, bclk_q;
    logic we_rise, avd_rise, bclk_rise;
    fcp_cycle_t cyc, pend_adr, baddr, rd_adr;
    logic [15:0] pend_dat;
    fcp_seq_t seq, next_seq;
    fcp_mode_t mode, next_mode;
    fcp_burst_t bst;
    logic [7:0] op, next_op, wd, rng_lo, rng_hi;
    logic a555, a2aa, a6, busy;
    logic do_cr, do_otp, do_pe, pe_er, do_prot, do_range, clr_stat;
    logic [15:0] cr, lock, stat_word, next_rdata, otp_new;
    logic lat_bad, rng_on, range_used, prot_fail, pgm_fail;
    logic [255:0] prot;
    logic [OTP_WORDS-1:0] otp_wr;
    logic [15:0] otp_mem [OTP_WORDS];
    logic [4:0] lat_cnt, latency;
    logic [7:0] pe_sect, otp_idx;
    logic otp_ok;

    fcp_sync #(.W(30)) u_sync (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({chip_sel_n_i, out_en_n_i, write_en_n_i, address_valid_n_i,
              burst_clk_i, write_protect_n_i, muxed_addr_data_lines_i,
              sector_base_addr_i}),
        .q_o(sync_q)
    );
    assign pin_s = sync_q[29:24];
    assign mad_s = sync_q[23:8];
    assign sect_s = sync_q[7:0];

    function automatic logic lat_ok(input logic [3:0] c);
        return (c >= LAT_MIN) && (c <= LAT_MAX);
    endfunction

    function automatic logic in_range(input logic [7:0] s);
        return rng_on && (s >= rng_lo) && (s <= rng_hi);
    endfunction

    function automatic logic [15:0] otp_rd(input logic [7:0] i);
        return otp_wr[i] ? otp_mem[i] : OTP_BLANK;
    endfunction

    // edge detection on the synchronised pins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            we_n_q <= 1'b1;
            avd_n_q <= 1'b1;
            bclk_q <= 1'b1;
            cyc <= '0;
        end else begin
            we_n_q <= pin_s.we_n;
            avd_n_q <= pin_s.avd_n;
            bclk_q <= pin_s.bclk;
            if (!pin_s.avd_n && !pin_s.cs_n) begin
                cyc <= {sect_s, mad_s};
            end
        end
    end
    assign we_rise = !we_n_q && pin_s.we_n && !pin_s.cs_n;
    assign avd_rise = !avd_n_q && pin_s.avd_n && !pin_s.cs_n;
    assign bclk_rise = !bclk_q && pin_s.bclk;

    assign wd = mad_s[7:0];
    assign a555 = cyc.low[10:0] == ADR_555;
    assign a2aa = cyc.low[10:0] == ADR_2AA;
    assign a6 = cyc.low[PROT_SEL_BIT];
    assign busy = pe_busy_i || (bst != BU_IDLE);
    assign latency = {1'b0, cr[CR_LAT_HI:CR_LAT_LO]} + LAT_OFS;

    // command decoder
    always_comb begin
        next_seq = seq;
        next_op = op;
        next_mode = mode;
        do_cr = 1'b0;
        do_otp = 1'b0;
        do_pe = 1'b0;
        pe_er = 1'b0;
        do_prot = 1'b0;
        do_range = 1'b0;
        clr_stat = 1'b0;
        if (we_rise) begin
            unique case (seq)
                SQ_IDLE: begin
                    if (wd == CMD_RESET) begin
                        next_mode = MD_ARRAY;
                    end else if (a555) begin
                        if (wd == CMD_STAT) begin
                            next_mode = MD_STAT;
                        end else if (wd == CMD_CLR) begin
                            clr_stat = 1'b1;
                        end else if (wd == CMD_CFG_ENTER) begin
                            next_mode = MD_CFG;
                        end else if (wd == CMD_OTP_ENTER && !pe_busy_i) begin
                            next_mode = MD_OTP;
                        end else if (wd == CMD_LOAD || wd == CMD_ERASE ||
                                     wd == CMD_PROT) begin
                            next_op = wd;
                            next_seq = SQ_C1;
                        end
                    end
                end
                SQ_C1: begin
                    next_seq = SQ_IDLE;
                    if (a2aa && op == CMD_ERASE && wd == CMD_ERASE_GO) begin
                        do_pe = 1'b1;
                        pe_er = 1'b1;
                    end else if (a2aa && ((op == CMD_LOAD && wd == WC_ONE) ||
                                 (op == CMD_PROT && wd == CMD_PROT))) begin
                        next_seq = SQ_C2;
                    end
                end
                SQ_C2: begin
                    next_seq = SQ_IDLE;
                    if (op == CMD_LOAD) begin
                        next_seq = SQ_C3;
                    end else if (wd == CMD_PROT) begin
                        do_prot = 1'b1;
                    end else if (wd == CMD_RANGE && !a6) begin
                        next_seq = SQ_C3;
                    end
                end
                SQ_C3: begin
                    next_seq = SQ_IDLE;
                    if (op == CMD_LOAD && a555 && wd == CMD_COMMIT) begin
                        if (mode == MD_CFG) begin
                            do_cr = 1'b1;
                        end else if (mode == MD_OTP) begin
                            do_otp = 1'b1;
                        end else begin
                            do_pe = 1'b1;
                        end
                    end else if (op == CMD_PROT && wd == CMD_RANGE && !a6 &&
                                 !range_used && cyc.sect >= pend_adr.sect) begin
                        do_range = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seq <= SQ_IDLE;
            op <= '0;
            mode <= MD_ARRAY;
            pend_adr <= '0;
            pend_dat <= '0;
        end else begin
            seq <= next_seq;
            op <= next_op;
            mode <= next_mode;
            if (we_rise && seq == SQ_C2) begin
                pend_adr <= cyc;
                pend_dat <= mad_s;
            end
        end
    end

    // configuration register; reset value selects async read
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cr <= CR_RST;
            lat_bad <= 1'b0;
        end else if (do_cr && !busy) begin
            if (lat_ok(pend_dat[CR_LAT_HI:CR_LAT_LO])) begin
                cr <= pend_dat;
                lat_bad <= 1'b0;
            end else begin
                cr <= {pend_dat[15], LAT_BAD, pend_dat[10:0]};
                lat_bad <= 1'b1;
            end
        end
    end

    // sector protection; the range lock has the last word until reset
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prot <= '0;
            rng_on <= 1'b0;
            range_used <= 1'b0;
            rng_lo <= '0;
            rng_hi <= '0;
        end else begin
            if (do_prot && !a6) begin
                prot <= '1;
            end else if (do_prot && !in_range(cyc.sect)) begin
                prot[cyc.sect] <= 1'b0;
            end
            if (do_range) begin
                rng_on <= 1'b1;
                range_used <= 1'b1;
                rng_lo <= pend_adr.sect;
                rng_hi <= cyc.sect;
            end
        end
    end

    // program and erase requests to the array engine
    assign pe_sect = pe_er ? cyc.sect : pend_adr.sect;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pe_start_o <= 1'b0;
            pe_erase_o <= 1'b0;
            pe_addr_o <= '0;
            pe_data_o <= '0;
        end else begin
            pe_start_o <= do_pe && !pe_busy_i && pin_s.wp_n &&
                !prot[pe_sect] && !in_range(pe_sect);
            if (do_pe) begin
                pe_erase_o <= pe_er;
                pe_addr_o <= pe_er ? cyc : pend_adr;
                pe_data_o <= pend_dat;
            end
        end
    end

    // secured area: only ones may turn to zeros
    assign otp_idx = pend_adr.low[7:0];
    assign otp_ok = !pe_busy_i &&
        (otp_idx[7] ? lock[LOCK_CUST] : lock[LOCK_FACT]);
    always_ff @(posedge sys_clk_i) begin
        if (do_otp) begin
            otp_mem[otp_idx] <= otp_new;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            otp_wr <= '0;
            lock <= LOCK_INIT;
        end else if (do_otp) begin
            otp_wr[otp_idx] <= 1'b1;
        end
    end

    // sticky status; a new failure beats a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prot_fail <= 1'b0;
            pgm_fail <= 1'b0;
        end else begin
            if (do_pe && (!pin_s.wp_n || prot[pe_sect] ||
                in_range(pe_sect))) begin
                prot_fail <= 1'b1;
            end else if (clr_stat) begin
                prot_fail <= 1'b0;
            end
            if (do_otp && |(~pend_dat & otp_new)) begin
                pgm_fail <= 1'b1;
            end else if (clr_stat) begin
                pgm_fail <= 1'b0;
            end
        end
    end

    // burst engine counts link clock edges after the address phase
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bst <= BU_IDLE;
            lat_cnt <= '0;
            baddr <= '0;
        end else if (pin_s.cs_n) begin
            bst <= BU_IDLE;
        end else if (avd_rise && pin_s.we_n) begin
            // a write cycle latches an address too but, as WE# is already low at the strobe, starts no burst
            baddr <= cyc;
            lat_cnt <= '0;
            bst <= cr[CR_SYNC_B] ? BU_IDLE : BU_LAT;
        end else if (bclk_rise) begin
            unique case (bst)
                BU_LAT: begin
                    lat_cnt <= lat_cnt + 5'h01;
                    if (lat_cnt + 5'h01 == latency) begin
                        bst <= BU_DATA;
                    end
                end
                BU_DATA: begin
                    if (cr[2:0] == BL_W8) begin
                        baddr.low[2:0] <= baddr.low[2:0] + 3'h1;
                    end else if (cr[2:0] == BL_W16) begin
                        baddr.low[3:0] <= baddr.low[3:0] + 4'h1;
                    end else if (mode == MD_OTP) begin
                        baddr.low[7:0] <= baddr.low[7:0] + 8'h01;
                    end else begin
                        baddr <= baddr + 24'h000001;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[ST_RDY] = !pe_busy_i;
        stat_word[ST_PFAIL] = pgm_fail;
        stat_word[ST_PROT] = prot_fail;
        rd_adr = (bst != BU_IDLE) ? baddr : cyc;
        otp_new = otp_rd(otp_idx);
        if (otp_ok) begin
            otp_new = otp_new & pend_dat;
        end
        unique case (mode)
            MD_ARRAY: next_rdata = array_rdata_i;
            MD_CFG: next_rdata = cr;
            MD_OTP: next_rdata = otp_rd(rd_adr.low[7:0]);
            MD_STAT: next_rdata = stat_word;
        endcase
    end

    // pin side; array data lags the address by one clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o <= 1'b1;
            ready_oe_n_o <= 1'b1;
            muxed_oe_n_o <= 1'b1;
            muxed_addr_data_lines_o <= '0;
            array_addr_o <= '0;
            drive_half_o <= 1'b0;
        end else begin
            ready_oe_n_o <= pin_s.cs_n;
            muxed_oe_n_o <= pin_s.cs_n || pin_s.oe_n;
            if (cr[CR_SYNC_B]) begin
                ready_o <= 1'b1;
            end else begin
                ready_o <= ((bst == BU_DATA) && !lat_bad) ==
                    cr[CR_POL_B];
            end
            muxed_addr_data_lines_o <= next_rdata;
            array_addr_o <= rd_adr;
            drive_half_o <= !cr[CR_DRV_B];
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    cfg_busy_hold_a: assert property (do_cr && busy |=> $stable(cr))
        else $error("config changed during bus operation");
    lat_fix_a: assert property (do_cr && !busy &&
        !lat_ok(pend_dat[CR_LAT_HI:CR_LAT_LO])
        |=> cr[CR_LAT_HI:CR_LAT_LO] == LAT_BAD && lat_bad)
        else $error("illegal latency not replaced");
    rdy_float_a: assert property (pin_s.cs_n |=> ready_oe_n_o)
        else $error("ready driven without chip select");
    async_rdy_a: assert property (cr[CR_SYNC_B] |=> ready_o)
        else $error("ready low in async mode");
    prot_block_a: assert property (do_pe && prot[pe_sect]
        |=> !pe_start_o && prot_fail)
        else $error("protected sector operation started");
    wp_block_a: assert property (do_pe && !pin_s.wp_n
        |=> !pe_start_o ##1 !pe_start_o)
        else $error("program started under write protect");
    wrap8_a: assert property (bst == BU_DATA && bclk_rise &&
        !pin_s.cs_n && !avd_rise && cr[2:0] == BL_W8 &&
        baddr.low[2:0] == 3'h7
        |=> baddr.low[2:0] == 3'h0 && $stable(baddr.low[15:3]))
        else $error("wrap 8 left its block");
    otp_wrap_a: assert property (bst == BU_DATA && bclk_rise &&
        !pin_s.cs_n && !avd_rise && mode == MD_OTP &&
        cr[2:0] == BL_CONT && baddr.low[7:0] == 8'hff
        |=> baddr.low[7:0] == 8'h00)
        else $error("secured burst did not wrap");
    range_once_a: assert property (range_used
        |=> range_used && $stable(rng_lo) && $stable(rng_hi))
        else $error("range lock changed twice");
    seq_abort_a: assert property (we_rise && seq == SQ_C1 &&
        !a2aa |=> seq == SQ_IDLE && $stable(cr))
        else $error("bad cycle did not abort");

    cfg_load_c: cover property (do_cr && !busy);
    range_c: cover property (do_range);
    burst_c: cover property (bst == BU_LAT ##[1:300] bst == BU_DATA);
    otp_pgm_c: cover property (do_otp && otp_ok);
endmodule

/* File: tb/fcp_host.sv */
`timescale 1ns/1ps
// host controller model; every level held 4 clocks so synced edges land
module fcp_host import fcp_pkg::*; (
    input wire logic clk_i,
    input wire logic [15:0] ad_i,
    input wire logic ready_i,
    input wire logic ready_oe_n_i,
    output fcp_pins_t pins_o,
    output logic [15:0] ad_o,
    output logic ad_oe_n_o,
    output logic [7:0] sect_o
);
    logic rdy_q [32];
    logic [15:0] dat_q [32];
    logic [15:0] rd_dat;
    logic rd_rdy;
    logic rd_oen;
    initial begin
        pins_o = 6'b111101;
        ad_o = 16'h0000;
        ad_oe_n_o = 1'b1;
        sect_o = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic addr_ph(input logic [7:0] s, input logic [15:0] a);
        tick(1);
        pins_o.cs_n <= 1'b0;
        pins_o.avd_n <= 1'b0;
        ad_o <= a;
        ad_oe_n_o <= 1'b0;
        sect_o <= s;
        tick(4);
        pins_o.avd_n <= 1'b1;
    endtask
    // released lines show the inverse of the last value, never a kind guess
    task automatic close_cyc();
        pins_o.cs_n <= 1'b1;
        pins_o.oe_n <= 1'b1;
        ad_oe_n_o <= 1'b1;
        ad_o <= ~ad_o;
        tick(4);
    endtask
    task automatic wr(input logic [7:0] s, input logic [15:0] a,
                      input logic [15:0] d);
        addr_ph(s, a);
        ad_o <= d;
        pins_o.we_n <= 1'b0;
        tick(4);
        pins_o.we_n <= 1'b1;
        tick(4);
        close_cyc();
    endtask
    task automatic rd_ph(input logic [15:0] a);
        ad_oe_n_o <= 1'b1;
        ad_o <= ~a;
        pins_o.oe_n <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] s, input logic [15:0] a);
        addr_ph(s, a);
        rd_ph(a);
        tick(8);
        @(negedge clk_i);
        rd_dat = ad_i;
        rd_rdy = ready_i;
        rd_oen = ready_oe_n_i;
        tick(1);
        close_cyc();
    endtask
    // burst clock runs only inside the burst, 8 system clocks a period
    task automatic burst(input logic [7:0] s, input logic [15:0] a,
                         input int n);
        addr_ph(s, a);
        rd_ph(a);
        tick(4);
        for (int e = 1; e <= n; e++) begin
            pins_o.bclk <= 1'b1;
            tick(4);
            pins_o.bclk <= 1'b0;
            tick(3);
            @(negedge clk_i);
            rdy_q[e] = ready_i;
            dat_q[e] = ad_i;
            tick(1);
        end
        close_cyc();
    endtask
    task automatic set_wp(input logic v);
        tick(1);
        pins_o.wp_n <= v;
    endtask
endmodule

/* File: tb/tb_flash_config_and_protection_cmds.sv */
`timescale 1ns/1ps
module tb_flash_config_and_protection_cmds import fcp_pkg::*;;
    logic sys_clk;
    logic rst_b;
    logic pe_busy;
    logic [15:0] rdata;
    fcp_pins_t pins;
    logic [15:0] h_ad;
    logic [7:0] h_sect;
    logic [15:0] d_ad;
    logic d_oe_n;
    logic rdy;
    logic rdy_oe_n;
    logic drv_half;
    logic [23:0] a_addr;
    logic pe_start;
    logic pe_erase;
    wire logic [15:0] bus;
    int bad_count = 0;
    int checks_done = 0;
    int starts = 0;
    assign bus = d_oe_n ? h_ad : d_ad;
    fcp_flash_cmd dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .chip_sel_n_i(pins.cs_n), .out_en_n_i(pins.oe_n),
        .write_en_n_i(pins.we_n), .address_valid_n_i(pins.avd_n),
        .burst_clk_i(pins.bclk), .write_protect_n_i(pins.wp_n),
        .muxed_addr_data_lines_i(bus), .sector_base_addr_i(h_sect),
        .muxed_addr_data_lines_o(d_ad), .muxed_oe_n_o(d_oe_n),
        .ready_o(rdy), .ready_oe_n_o(rdy_oe_n), .drive_half_o(drv_half),
        .pe_busy_i(pe_busy), .array_rdata_i(rdata), .array_addr_o(a_addr),
        .pe_start_o(pe_start), .pe_erase_o(pe_erase), .pe_addr_o(),
        .pe_data_o());
    fcp_host host (.clk_i(sys_clk), .ad_i(bus), .ready_i(rdy),
        .ready_oe_n_i(rdy_oe_n), .pins_o(pins), .ad_o(h_ad),
        .ad_oe_n_o(), .sect_o(h_sect));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // array stand-in: word content is its address with a fixed scramble
    always @(posedge sys_clk) begin
        rdata <= a_addr[15:0] ^ 16'hc300;
        if (pe_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] cv(logic [3:0] c, logic d, logic [2:0] b);
        return {1'b0, c, 3'b111, d, 4'b1001, b};
    endfunction
    function automatic int first();
        for (int e = 1; e < 32; e++) begin
            if (host.rdy_q[e] === 1'b1) begin
                return e;
            end
        end
        return 0;
    endfunction
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [7:0] s, input logic [10:0] a,
                       input logic [7:0] c);
        host.wr(s, {5'h00, a}, {8'h00, c});
    endtask
    task automatic cfg(input logic [15:0] v, input logic bad);
        cmd(8'h00, ADR_555, CMD_CFG_ENTER);
        cmd(8'h00, ADR_555, CMD_LOAD);
        cmd(8'h00, bad ? ADR_555 : ADR_2AA, WC_ONE);
        host.wr(8'h00, 16'h0000, v);
        cmd(8'h00, ADR_555, CMD_COMMIT);
        cmd(8'h00, 11'h000, CMD_RESET);
    endtask
    task automatic try_prog(input logic [7:0] s, input int n);
        int s0;
        s0 = starts;
        cmd(s, ADR_555, CMD_LOAD);
        cmd(s, ADR_2AA, WC_ONE);
        host.wr(s, 16'h0100, 16'h1234);
        cmd(s, ADR_555, CMD_COMMIT);
        chk(24'(starts - s0), 24'(n));
    endtask
    task automatic prot(input logic [7:0] s, input logic up);
        cmd(s, ADR_555, CMD_PROT);
        cmd(s, ADR_2AA, CMD_PROT);
        host.wr(s, {9'h000, up, 6'h00}, {8'h00, CMD_PROT});
    endtask
    task automatic range(input logic [7:0] lo, input logic [7:0] hi);
        cmd(8'h00, ADR_555, CMD_PROT);
        cmd(8'h00, ADR_2AA, CMD_PROT);
        cmd(lo, 11'h000, CMD_RANGE);
        cmd(hi, 11'h000, CMD_RANGE);
    endtask
    task automatic stat(input logic e);
        cmd(8'h00, ADR_555, CMD_STAT);
        host.rd(8'h00, 16'h0555);
        chk(host.rd_dat[ST_PROT], e);
        cmd(8'h00, 11'h000, CMD_RESET);
    endtask
    task automatic t_reset();
        int n;
        do_reset();
        chk(drv_half, 1'b0);
        chk({rdy_oe_n, d_oe_n}, 2'b11);
        host.rd(8'h01, 16'h0012);
        chk(host.rd_dat, 16'h0012 ^ 16'hc300);
        chk({host.rd_rdy, host.rd_oen}, 2'b10);
        host.burst(8'h01, 16'h0000, 14);
        n = 0;
        for (int e = 1; e <= 14; e++) n += int'(host.rdy_q[e] === 1'b1);
        chk(24'(n), 24'd14);
        cmd(8'h00, ADR_555, CMD_OTP_ENTER);
        host.rd(8'h00, 16'h00ff);
        chk(host.rd_dat, OTP_BLANK);
        cmd(8'h00, 11'h000, CMD_RESET);
    endtask
    task automatic t_drive();
        cfg(cv(4'h1, 1'b0, BL_CONT), 1'b0);
        chk(drv_half, 1'b1);
        pe_busy <= 1'b1;
        cfg(cv(4'h1, 1'b1, BL_CONT), 1'b0);
        pe_busy <= 1'b0;
        chk(drv_half, 1'b1);
        cfg(cv(4'h1, 1'b1, BL_CONT), 1'b1);
        chk(drv_half, 1'b1);
        cfg(cv(4'h1, 1'b1, BL_CONT), 1'b0);
        chk(drv_half, 1'b0);
    endtask
    task automatic t_lat();
        logic [3:0] c;
        int f;
        for (int i = 0; i < 2; i++) begin
            c = (i == 0) ? 4'h1 : 4'h8;
            cfg(cv(c, 1'b1, BL_CONT), 1'b0);
            host.burst(8'h01, 16'h0010, int'(c) + 4);
            f = first();
            chk(24'(f), 24'(c + 2));
            chk(host.dat_q[f], 16'h0010 ^ 16'hc300);
            chk(host.dat_q[f + 1], 16'h0011 ^ 16'hc300);
        end
    endtask
    task automatic t_wrap();
        logic [2:0] bl [3] = '{BL_W8, BL_W16, BL_CONT};
        logic [15:0] st [3] = '{16'h0005, 16'h000e, 16'h000e};
        logic [15:0] m [3] = '{16'h0007, 16'h000f, 16'hffff};
        logic [15:0] ex;
        for (int i = 0; i < 3; i++) begin
            cfg(cv(4'h1, 1'b1, bl[i]), 1'b0);
            host.burst(8'h02, st[i], 9);
            for (int k = 0; k < 6; k++) begin
                ex = (st[i] & ~m[i]) | ((st[i] + 16'(k)) & m[i]);
                chk(host.dat_q[3 + k], ex ^ 16'hc300);
            end
        end
        cmd(8'h00, ADR_555, CMD_OTP_ENTER);
        try_prog(8'h00, 0);
        host.burst(8'h00, 16'h00ff, 5);
        chk(host.dat_q[3], OTP_BLANK);
        chk(host.dat_q[4], 16'h1234);
        cmd(8'h00, 11'h000, CMD_RESET);
        cfg(cv(4'hc, 1'b1, BL_CONT), 1'b0);
        host.burst(8'h01, 16'h0000, 16);
        chk(24'(first()), 24'd0);
    endtask
    task automatic t_prot();
        int n;
        do_reset();
        try_prog(8'h05, 1);
        prot(8'h00, 1'b0);
        try_prog(8'h05, 0);
        stat(1'b1);
        cmd(8'h00, ADR_555, CMD_CLR);
        stat(1'b0);
        prot(8'h05, 1'b1);
        try_prog(8'h05, 1);
        try_prog(8'h06, 0);
        n = starts;
        cmd(8'h05, ADR_555, CMD_ERASE);
        cmd(8'h05, ADR_2AA, CMD_ERASE_GO);
        cmd(8'h06, ADR_555, CMD_ERASE);
        cmd(8'h06, ADR_2AA, CMD_ERASE_GO);
        chk(24'(starts - n), 24'd1);
        chk(pe_erase, 1'b1);
        host.set_wp(1'b0);
        try_prog(8'h05, 0);
        host.set_wp(1'b1);
        do_reset();
        range(8'h02, 8'h04);
        prot(8'h03, 1'b1);
        try_prog(8'h03, 0);
        try_prog(8'h05, 1);
        range(8'h05, 8'h06);
        try_prog(8'h06, 1);
    endtask
    initial begin
        rst_b = 1'b0;
        pe_busy = 1'b0;
        t_reset();
        t_drive();
        t_lat();
        t_wrap();
        t_prot();
        summarize();
    end
    // a hang is cut short here and counted as a mismatch
    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule
